/* File: tag_cmd_pkg.sv */
// Package of command codes, states and timing counts for the tag anticollision link
package tag_cmd_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_PREFIX = 8'h06;
    localparam logic [7:0] CMD_START_INV_2ND = 8'h00;
    localparam logic [7:0] CMD_SLOT_ZERO_2ND = 8'h04;
    localparam logic [3:0] PROBE_LOW_CODE = 4'h6;
    localparam logic [7:0] CMD_BLOCK_FETCH = 8'h08;
    localparam logic [7:0] CMD_BLOCK_STORE = 8'h09;
    localparam logic [7:0] CMD_FETCH_UID = 8'h0B;
    localparam logic [7:0] CMD_RETURN_INV = 8'h0C;
    localparam logic [7:0] CMD_CHOOSE_TAG = 8'h0E;
    localparam logic [7:0] CMD_FINISH_PARK = 8'h0F;

    // ------------------------------------------------------------
    // Field positions, reset values and search figures
    // ------------------------------------------------------------
    localparam int SLOT_LSB = 0;
    localparam int SLOT_MSB = 3;
    localparam logic [3:0] LAST_SLOT = 4'hF;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [7:0] ID_RESET = 8'h00;
    // Reader waits this many cycles plus one for an answer to a probe
    localparam logic [3:0] ANSWER_WAIT = 4'h8;

    // ------------------------------------------------------------
    // Tag life-cycle states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        TAG_READY = 5'b00001,
        TAG_INVENTORY = 5'b00010,
        TAG_SELECTED = 5'b00100,
        TAG_DESELECTED = 5'b01000,
        TAG_PARKED = 5'b10000
    } tag_state_t;

    // ------------------------------------------------------------
    // Reader search states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        RD_IDLE = 7'b0000001,
        RD_SEND = 7'b0000010,
        RD_SEND2 = 7'b0000100,
        RD_WAIT = 7'b0001000,
        RD_NEXT = 7'b0010000,
        RD_CHOOSE = 7'b0100000,
        RD_DONE = 7'b1000000
    } rd_state_t;

    // Next value of a 16-bit Galois random generator
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        lfsr_step = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
    endfunction

endpackage

/* File: tag_link_if.sv */
// Interface joining the reader end and the tag end: command bytes down, answers up
`timescale 1ns/10ps
interface tag_link_if;
    logic [7:0] cmd_byte;
    logic cmd_valid;
    logic cmd_last;
    logic [7:0] ans_byte;
    logic ans_valid;

    modport reader_end (output cmd_byte, output cmd_valid, output cmd_last, input ans_byte, input ans_valid);
    modport tag_end (input cmd_byte, input cmd_valid, input cmd_last, output ans_byte, output ans_valid);
endinterface

/* File: tag_anticollision_commands.sv */
// Tag end: command decoding and anticollision state logic
// Functional notes
// - Reader handles zero, one or many answers
// - After slot 15 reader may choose tag; this reader chooses each tag right after its clean answer
// - Collision seen: reader runs another pass
// - Reader may stop when all identified
// - Start-inventory is 06h then 00h
// - Slot-zero 06h 04h; probe low nibble 6
// - Codes 08h, 09h, 0Bh are recognised
// - Ready plus start: Inventory, new identifier, answer
// - Start answer ignores slot nibble
// - Single tag: start answer alone suffices
// - Slot-zero redraws low nibble, answers on zero
// - Draw nibble first, then compare zero
// - Probe answers when nibble equals slot
// - Matching choose-tag: Selected, answer identifier
// - Only Inventory tags answer searches
`timescale 1ns/10ps
module tag_anticollision_commands
    import tag_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    tag_link_if.tag_end link,
    output logic [7:0] tag_identifier,
    output logic [4:0] tag_state,
    output logic [7:0] last_cmd,
    output logic last_cmd_known
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    tag_state_t state_reg, state_next;
    logic [7:0] id_reg, id_next;
    logic [15:0] lfsr_reg;
    logic prefix_reg, prefix_next;
    logic [7:0] arg_cmd_reg, arg_cmd_next;
    logic arg_wait_reg, arg_wait_next;
    logic [7:0] ans_reg, ans_next;
    logic ans_vld_reg, ans_vld_next;
    logic [7:0] last_reg, last_next;
    logic known_reg, known_next;

    // ------------------------------------------------------------
    // Decode of the received byte
    // ------------------------------------------------------------
    wire logic [7:0] b = link.cmd_byte;
    wire logic [15:0] rnd = lfsr_step(lfsr_reg);
    wire logic in_inv = (state_reg == TAG_INVENTORY);
    wire logic is_prefix = (b == CMD_PREFIX);
    wire logic is_probe = (b[3:0] == PROBE_LOW_CODE) && (b[7:4] != 4'h0);
    wire logic is_start = prefix_reg && (b == CMD_START_INV_2ND);
    wire logic is_slot0 = prefix_reg && (b == CMD_SLOT_ZERO_2ND);
    wire logic is_single = (b == CMD_BLOCK_FETCH) || (b == CMD_BLOCK_STORE) || (b == CMD_FETCH_UID)
        || (b == CMD_RETURN_INV) || (b == CMD_CHOOSE_TAG) || (b == CMD_FINISH_PARK);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        id_next = id_reg;
        prefix_next = prefix_reg;
        arg_cmd_next = arg_cmd_reg;
        arg_wait_next = arg_wait_reg;
        ans_next = ans_reg;
        ans_vld_next = 1'b0;
        last_next = last_reg;
        known_next = known_reg;
        if (state_reg == TAG_READY)
        begin
            id_next = rnd[7:0]; // Identifier stays random while Ready
        end
        if (link.cmd_valid && state_reg != TAG_PARKED)
        begin
            prefix_next = 1'b0;
            last_next = b;
            known_next = 1'b0;
            if (arg_wait_reg)
            begin
                arg_wait_next = 1'b0;
                known_next = 1'b1;
                if (arg_cmd_reg == CMD_CHOOSE_TAG)
                begin
                    if (b == id_reg && (in_inv || state_reg == TAG_SELECTED))
                    begin
                        state_next = TAG_SELECTED;
                        ans_next = id_reg;
                        ans_vld_next = 1'b1;
                    end
                    else if (state_reg == TAG_SELECTED)
                    begin
                        state_next = TAG_DESELECTED;
                    end
                end
            end
            else if (is_start)
            begin
                known_next = 1'b1;
                if (state_reg == TAG_READY)
                begin
                    state_next = TAG_INVENTORY;
                    id_next = rnd[7:0];
                    ans_next = rnd[7:0];
                    ans_vld_next = 1'b1;
                end
            end
            else if (is_slot0)
            begin
                known_next = 1'b1;
                if (in_inv)
                begin
                    id_next = {id_reg[7:4], rnd[SLOT_MSB:SLOT_LSB]};
                    ans_next = id_next;
                    ans_vld_next = (rnd[SLOT_MSB:SLOT_LSB] == 4'h0);
                end
            end
            else if (is_prefix)
            begin
                prefix_next = 1'b1;
                known_next = 1'b1;
            end
            else if (is_probe)
            begin
                known_next = 1'b1;
                if (in_inv && id_reg[SLOT_MSB:SLOT_LSB] == b[7:4])
                begin
                    ans_next = id_reg;
                    ans_vld_next = 1'b1;
                end
            end
            else if (is_single)
            begin
                known_next = 1'b1;
                if (b == CMD_CHOOSE_TAG)
                begin
                    arg_wait_next = 1'b1;
                    arg_cmd_next = b;
                end
                else if (b == CMD_RETURN_INV && state_reg == TAG_SELECTED)
                begin
                    state_next = TAG_INVENTORY;
                end
                else if (b == CMD_FINISH_PARK && state_reg == TAG_SELECTED)
                begin
                    state_next = TAG_PARKED;
                end
            end
            // Any other byte falls through with no state change
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= TAG_READY;
            id_reg <= ID_RESET;
            lfsr_reg <= LFSR_SEED;
            prefix_reg <= 1'b0;
            arg_cmd_reg <= 8'h00;
            arg_wait_reg <= 1'b0;
            ans_reg <= 8'h00;
            ans_vld_reg <= 1'b0;
            last_reg <= 8'h00;
            known_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            id_reg <= id_next;
            lfsr_reg <= rnd;
            prefix_reg <= prefix_next;
            arg_cmd_reg <= arg_cmd_next;
            arg_wait_reg <= arg_wait_next;
            ans_reg <= ans_next;
            ans_vld_reg <= ans_vld_next;
            last_reg <= last_next;
            known_reg <= known_next;
        end
    end

    // Outputs straight from flip-flops
    assign link.ans_byte = ans_reg;
    assign link.ans_valid = ans_vld_reg;
    assign tag_identifier = id_reg;
    assign tag_state = state_reg;
    assign last_cmd = last_reg;
    assign last_cmd_known = known_reg;

endmodule

/* File: tag_search_reader.sv */
// Reader end: runs the slot search and chooses each identified tag
`timescale 1ns/10ps
module tag_search_reader
    import tag_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    tag_link_if.reader_end link,
    input wire logic search_start,
    input wire logic ans_collision,
    output logic search_busy,
    output logic search_done,
    output logic [7:0] found_id,
    output logic found_valid,
    output logic [7:0] found_count
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    rd_state_t st_reg;
    logic [3:0] slot_reg;
    logic [3:0] wait_reg;
    logic got_reg;
    logic coll_reg;
    logic pass_coll_reg;
    logic first_reg;
    logic [7:0] cap_reg;
    logic [7:0] cmd_reg;
    logic cvld_reg;
    logic clast_reg;
    logic [7:0] fid_reg;
    logic fvld_reg;
    logic [7:0] cnt_reg;

    // Slot zero goes out as a two-byte code, others as one probe byte
    wire logic [7:0] probe_byte = {slot_reg, PROBE_LOW_CODE};

    // ------------------------------------------------------------
    // Search sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= RD_IDLE;
            slot_reg <= 4'h0;
            wait_reg <= 4'h0;
            got_reg <= 1'b0;
            coll_reg <= 1'b0;
            pass_coll_reg <= 1'b0;
            first_reg <= 1'b0;
            cap_reg <= 8'h00;
            cmd_reg <= 8'h00;
            cvld_reg <= 1'b0;
            clast_reg <= 1'b0;
            fid_reg <= 8'h00;
            fvld_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end
        else
        begin
            cvld_reg <= 1'b0;
            clast_reg <= 1'b0;
            fvld_reg <= 1'b0;
            case (st_reg)
                RD_IDLE:
                begin
                    if (search_start)
                    begin
                        st_reg <= RD_SEND;
                        first_reg <= 1'b1;
                        slot_reg <= 4'h0;
                        pass_coll_reg <= 1'b0;
                        cnt_reg <= 8'h00;
                    end
                end
                RD_SEND:
                begin
                    cvld_reg <= 1'b1;
                    if (first_reg || slot_reg == 4'h0)
                    begin
                        cmd_reg <= CMD_PREFIX;
                        st_reg <= RD_SEND2;
                    end
                    else
                    begin
                        cmd_reg <= probe_byte;
                        clast_reg <= 1'b1;
                        st_reg <= RD_WAIT;
                        wait_reg <= ANSWER_WAIT;
                        got_reg <= 1'b0;
                        coll_reg <= 1'b0;
                    end
                end
                RD_SEND2:
                begin
                    cvld_reg <= 1'b1;
                    clast_reg <= 1'b1;
                    cmd_reg <= first_reg ? CMD_START_INV_2ND : CMD_SLOT_ZERO_2ND;
                    st_reg <= RD_WAIT;
                    wait_reg <= ANSWER_WAIT;
                    got_reg <= 1'b0;
                    coll_reg <= 1'b0;
                end
                RD_WAIT:
                begin
                    // Zero, one or many answers are all handled
                    if (link.ans_valid)
                    begin
                        if (ans_collision || got_reg)
                        begin
                            coll_reg <= 1'b1;
                        end
                        got_reg <= 1'b1;
                        cap_reg <= link.ans_byte;
                    end
                    if (wait_reg == 4'h0)
                    begin
                        st_reg <= RD_NEXT;
                    end
                    else
                    begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                RD_NEXT:
                begin
                    if (coll_reg)
                    begin
                        pass_coll_reg <= 1'b1;
                    end
                    if (got_reg && !coll_reg)
                    begin
                        fid_reg <= cap_reg; // Record each clean identifier
                        fvld_reg <= 1'b1;
                        cnt_reg <= cnt_reg + 8'h01;
                        st_reg <= RD_CHOOSE;
                    end
                    else if (first_reg)
                    begin
                        first_reg <= 1'b0;
                        st_reg <= got_reg ? RD_SEND : RD_DONE;
                    end
                    else if (slot_reg == LAST_SLOT)
                    begin
                        slot_reg <= 4'h0;
                        st_reg <= (pass_coll_reg || coll_reg) ? RD_SEND : RD_DONE;
                        pass_coll_reg <= 1'b0;
                    end
                    else
                    begin
                        slot_reg <= slot_reg + 4'h1;
                        st_reg <= RD_SEND;
                    end
                end
                RD_CHOOSE:
                begin
                    // Choose-tag code, then the identifier byte
                    cvld_reg <= 1'b1;
                    if (cmd_reg != CMD_CHOOSE_TAG)
                    begin
                        cmd_reg <= CMD_CHOOSE_TAG;
                    end
                    else
                    begin
                        cmd_reg <= fid_reg;
                        clast_reg <= 1'b1;
                        got_reg <= 1'b0;
                        st_reg <= RD_NEXT; // Advance as after an empty slot
                    end
                end
                default:
                begin
                    st_reg <= RD_IDLE;
                end
            endcase
        end
    end

    // Outputs straight from flip-flops, except busy and done, which are decoded from the state register
    assign link.cmd_byte = cmd_reg;
    assign link.cmd_valid = cvld_reg;
    assign link.cmd_last = clast_reg;
    assign search_busy = (st_reg != RD_IDLE) && (st_reg != RD_DONE);
    assign search_done = (st_reg == RD_DONE);
    assign found_id = fid_reg;
    assign found_valid = fvld_reg;
    assign found_count = cnt_reg;

endmodule

/* File: tag_link_assertions.sv */
// Checker of the command and answer traffic on one reader-to-tag link
`timescale 1ns/10ps
module tag_link_assertions
    import tag_cmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_valid,
    input wire logic cmd_last,
    input wire logic [7:0] ans_byte,
    input wire logic ans_valid
);
    // ------------------------------------------------------------
    // Clocking and byte conditions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // Opening bytes of the two-byte commands and a slot probe
    wire logic prefix_first = cmd_valid && cmd_byte == CMD_PREFIX && !cmd_last;
    wire logic choose_first = cmd_valid && cmd_byte == CMD_CHOOSE_TAG && !cmd_last;
    wire logic probe_byte = cmd_valid && cmd_byte[3:0] == PROBE_LOW_CODE && cmd_byte[7:4] != 4'h0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_answer_has_cause: assert property (ans_valid |-> $past(cmd_valid) && $past(cmd_last))
        else $error("answer without a command byte just before");
    a_answer_one_cycle: assert property (ans_valid |=> !ans_valid)
        else $error("answer pulse longer than one cycle");
    a_prefix_pairs_up: assert property (prefix_first |=> cmd_valid && cmd_last
        && (cmd_byte == CMD_START_INV_2ND || cmd_byte == CMD_SLOT_ZERO_2ND))
        else $error("prefix byte not followed by a second byte");
    a_slot_zero_nibble: assert property (prefix_first ##1 (cmd_valid && cmd_byte == CMD_SLOT_ZERO_2ND)
        ##1 ans_valid |-> ans_byte[3:0] == 4'h0)
        else $error("slot zero answer with nonzero slot nibble");
    a_probe_slot_match: assert property (!choose_first ##1 probe_byte ##1 ans_valid
        |-> ans_byte[3:0] == $past(cmd_byte[7:4]))
        else $error("probe answer from a tag in another slot");
    a_choose_echo_id: assert property (choose_first ##1 (cmd_valid && cmd_last) ##1 ans_valid
        |-> ans_byte == $past(cmd_byte))
        else $error("choose answer differs from the sent identifier");
    a_start_wait_quiet: assert property (prefix_first ##1 (cmd_valid && cmd_byte == CMD_START_INV_2ND)
        |=> !cmd_valid [*8])
        else $error("reader sent a byte inside the answer window");
    a_last_with_valid: assert property (cmd_last |-> cmd_valid)
        else $error("last marker on an idle cycle");

    // Main scenarios seen on the link
    c_start_answer: cover property (prefix_first ##1 (cmd_valid && cmd_byte == CMD_START_INV_2ND) ##1 ans_valid);
    c_probe_answer: cover property (probe_byte ##1 ans_valid);
    c_choose_answer: cover property (choose_first ##1 cmd_valid ##1 ans_valid);
endmodule

/* File: tag_anticollision_commands_tb.sv */
// Self-checking bench: reader with two tags on a merged link, and one tag driven directly
`timescale 1ns/10ps
module tag_anticollision_commands_tb;
    import tag_cmd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rst_b2 = 1'b0;
    logic search_start = 1'b0;
    int bad_count = 0;
    int tests_run = 0;
    int answers = 0;
    logic [7:0] found_q[$];
    logic [7:0] id_a, id_b, id_d, last_d, fid, fcount, prev_id, ans_seen_byte;
    logic [4:0] st_a, st_b, st_d;
    logic known_d, busy, done, fvalid, ans_seen;
    logic [7:0] code_table [5] = '{8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0F};
    logic [7:0] bad_table [5] = '{8'h01, 8'h05, 8'h0A, 8'h0D, 8'hFF};
    tag_link_if link_r();
    tag_link_if link_a();
    tag_link_if link_b();
    tag_link_if link_d();
    wire logic collide = link_a.ans_valid & link_b.ans_valid;

    // Commands go to both tags; their answers merge towards the reader
    assign link_a.cmd_byte = link_r.cmd_byte;
    assign link_a.cmd_valid = link_r.cmd_valid;
    assign link_a.cmd_last = link_r.cmd_last;
    assign link_b.cmd_byte = link_r.cmd_byte;
    assign link_b.cmd_valid = link_r.cmd_valid;
    assign link_b.cmd_last = link_r.cmd_last;
    assign link_r.ans_valid = link_a.ans_valid | link_b.ans_valid;
    assign link_r.ans_byte = link_a.ans_valid ? link_a.ans_byte : link_b.ans_byte;

    // Design ends and the link checker
    tag_search_reader tag_search_reader_inst (.ref_clk(ref_clk), .rst_b(rst_b), .link(link_r.reader_end),
        .search_start(search_start), .ans_collision(collide), .search_busy(busy), .search_done(done),
        .found_id(fid), .found_valid(fvalid), .found_count(fcount));
    tag_anticollision_commands tag_anticollision_commands_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .link(link_a.tag_end), .tag_identifier(id_a), .tag_state(st_a), .last_cmd(), .last_cmd_known());
    tag_anticollision_commands tag_anticollision_commands_b_inst (.ref_clk(ref_clk), .rst_b(rst_b2),
        .link(link_b.tag_end), .tag_identifier(id_b), .tag_state(st_b), .last_cmd(), .last_cmd_known());
    tag_anticollision_commands tag_anticollision_commands_d_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .link(link_d.tag_end), .tag_identifier(id_d), .tag_state(st_d), .last_cmd(last_d), .last_cmd_known(known_d));
    tag_link_assertions tag_link_assertions_inst (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_byte(link_a.cmd_byte),
        .cmd_valid(link_a.cmd_valid), .cmd_last(link_a.cmd_last), .ans_byte(link_a.ans_byte),
        .ans_valid(link_a.ans_valid));

    // ------------------------------------------------------------
    // Clock, collection of found identifiers, watchdog
    // ------------------------------------------------------------
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (fvalid === 1'b1)
            found_q.push_back(fid);
    end

    initial
    begin
        repeat (45000) @(posedge ref_clk);
        bad_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Compare, drive and closing tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic chk_state(input logic [4:0] got, input logic [4:0] exp);
        chk_byte({3'b000, got}, {3'b000, exp});
    endtask

    // Sends one or two bytes to the direct tag and records its answer
    task automatic send_d(input logic [7:0] b0, input logic [7:0] b1, input bit two);
        link_d.cmd_valid = 1'b1;
        link_d.cmd_last = !two;
        link_d.cmd_byte = b0;
        if (two)
        begin
            @(posedge ref_clk);
            #1;
            link_d.cmd_byte = b1;
            link_d.cmd_last = 1'b1;
        end
        @(posedge ref_clk);
        #1;
        link_d.cmd_valid = 1'b0;
        link_d.cmd_last = 1'b0;
        ans_seen = link_d.ans_valid;
        ans_seen_byte = link_d.ans_byte;
        @(posedge ref_clk);
        #1;
        chk_bit(link_d.ans_valid, 1'b0);
    endtask

    // Starts a reader search and waits for its end under a bound
    task automatic run_search;
        int n;
        search_start = 1'b1;
        @(posedge ref_clk);
        #1;
        search_start = 1'b0;
        chk_bit(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 15000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk_bit(done, 1'b1);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        link_d.cmd_byte = 8'h00;
        link_d.cmd_valid = 1'b0;
        link_d.cmd_last = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        @(posedge ref_clk);
        #1;
        chk_state(st_d, TAG_READY);
        // Recognised and unknown single codes while ready
        for (int i = 0; i < 5; i++)
        begin
            send_d(code_table[i], 8'h00, 1'b0);
            chk_bit(known_d, 1'b1);
            chk_bit(ans_seen, 1'b0);
            send_d(bad_table[i], 8'h00, 1'b0);
            chk_byte(last_d, bad_table[i]);
            chk_bit(known_d, 1'b0);
            chk_bit(ans_seen, 1'b0);
            chk_state(st_d, TAG_READY);
        end
        // Searches and a broken pair are ignored while ready
        send_d(8'h36, 8'h00, 1'b0);
        chk_bit(ans_seen, 1'b0);
        send_d(CMD_PREFIX, CMD_SLOT_ZERO_2ND, 1'b1);
        chk_bit(ans_seen, 1'b0);
        send_d(CMD_PREFIX, 8'h01, 1'b1);
        chk_bit(ans_seen, 1'b0);
        chk_state(st_d, TAG_READY);
        send_d(CMD_PREFIX, CMD_START_INV_2ND, 1'b1);
        chk_bit(ans_seen, 1'b1);
        chk_byte(ans_seen_byte, id_d);
        chk_state(st_d, TAG_INVENTORY);
        send_d(CMD_PREFIX, CMD_START_INV_2ND, 1'b1);
        chk_bit(ans_seen, 1'b0);
        send_d(CMD_RETURN_INV, 8'h00, 1'b0);
        send_d(CMD_FINISH_PARK, 8'h00, 1'b0);
        chk_state(st_d, TAG_INVENTORY);
        $display("test direct_decode done, bad_count %0d", bad_count);
        // Slot zero redraw, then every probe slot
        prev_id = id_d;
        send_d(CMD_PREFIX, CMD_SLOT_ZERO_2ND, 1'b1);
        chk_byte({id_d[7:4], 4'h0}, {prev_id[7:4], 4'h0});
        chk_bit(ans_seen, id_d[3:0] == 4'h0);
        answers = int'(ans_seen === 1'b1);
        for (int s = 1; s < 16; s++)
        begin
            send_d({4'(s), PROBE_LOW_CODE}, 8'h00, 1'b0);
            chk_bit(ans_seen, id_d[3:0] == 4'(s));
            if (ans_seen === 1'b1)
                chk_byte(ans_seen_byte, id_d);
            answers += int'(ans_seen === 1'b1);
        end
        chk_byte(8'(answers), 8'h01);
        // Choose, return, choose again, park
        send_d(CMD_CHOOSE_TAG, id_d ^ 8'h80, 1'b1);
        chk_bit(ans_seen, 1'b0);
        chk_state(st_d, TAG_INVENTORY);
        send_d(CMD_CHOOSE_TAG, id_d, 1'b1);
        chk_bit(ans_seen, 1'b1);
        chk_byte(ans_seen_byte, id_d);
        chk_state(st_d, TAG_SELECTED);
        send_d(CMD_RETURN_INV, 8'h00, 1'b0);
        chk_state(st_d, TAG_INVENTORY);
        send_d(CMD_CHOOSE_TAG, id_d, 1'b1);
        send_d(CMD_FINISH_PARK, 8'h00, 1'b0);
        chk_bit(ans_seen, 1'b0);
        chk_state(st_d, TAG_PARKED);
        send_d(CMD_PREFIX, CMD_START_INV_2ND, 1'b1);
        chk_bit(ans_seen, 1'b0);
        $display("test direct_search done, bad_count %0d", bad_count);
        // Reader with a single tag in the field
        run_search();
        chk_byte(fcount, 8'h01);
        chk_byte(8'(found_q.size()), 8'h01);
        chk_byte(found_q[0], id_a);
        chk_state(st_a, TAG_SELECTED);
        $display("test single_tag done, bad_count %0d", bad_count);
        // Reader with two tags, released at different times
        rst_b = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        found_q.delete();
        repeat (3) @(posedge ref_clk);
        #1;
        rst_b2 = 1'b1;
        run_search();
        chk_byte(fcount, 8'h02);
        chk_byte(8'(found_q.size()), 8'h02);
        chk_bit((found_q[0] === id_a && found_q[1] === id_b) || (found_q[0] === id_b && found_q[1] === id_a), 1'b1);
        chk_bit(st_a === TAG_SELECTED || st_a === TAG_DESELECTED, 1'b1);
        chk_bit(st_b === TAG_SELECTED || st_b === TAG_DESELECTED, 1'b1);
        $display("test two_tags done, bad_count %0d", bad_count);
        tally_and_finish();
    end
endmodule
